// File: core/mpwm_ctrl.sv
// six-output modulator control: registers, counter, reload and pin forcing
// Overview of operation
// - cleared off bit forces pins off immediately
// - set off bit releases pins at reload
// - selective disable forces masked outputs off
// - alignment bit picks edge or center waveform
// - converter triggers only while trigger enabled
// - ready bit moves holding values at reload
// - disabled: counter stopped, outputs forced off
// - enabled: modulator runs, pins driven
// - interval field buffered until period end
// - reload every 1, 2, 4, 8 periods
// - mode bit: three pairs or six channels
// - polarity bits invert pairs two, one, zero
// - prescaler divides clock by 1,2,4,8
// - reload value sets period, doubled centered
// - complementary pairs get programmable dead time
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module mpwm_ctrl
  import mpwm_pkg::*;
#(
  parameter logic [5:0] OFF_STATE = 6'h00
)(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // output pins
  output logic      [NUM_CH-1:0] pwm_out,
  output logic      [NUM_CH-1:0] pwm_oe_out,
  // events to neighbouring logic
  output logic                   adc_trig_out,
  output logic                   reload_evt_out
);

  logic [7:0]       ctl_main_q;
  logic [7:0]       ctl_aux_q;
  logic [7:0]       dead_q;
  logic [5:0]       mask_q;
  logic [11:0]      reload_h_q;
  logic [15:0]      duty_h_q [NUM_CH];
  logic [11:0]      reload_w_q;
  logic [15:0]      duty_w_q [NUM_CH];
  logic [1:0]       div_w_q;
  logic [1:0]       intv_w_q;
  logic [CNT_W-1:0] cnt_q;
  mpwm_dir_t        dir_q;
  logic [2:0]       per_cnt_q;
  logic             en_prev_q;
  logic             release_q;
  logic [7:0]       rdata_q;
  logic [5:0]       pwm_q;
  logic             trig_q;

  logic             en;
  logic             align;
  logic             indep;
  logic [2:0]       pol;
  logic             tick;
  logic [11:0]      r_eff;
  logic             period_end;
  logic             per_match;
  logic             start_evt;
  logic             reload_evt;
  logic             duty_hit;
  logic [11:0]      duty_off;
  logic [2:0]       duty_idx;
  logic [7:0]       rd_mux;
  logic [5:0]       raw;
  logic [5:0]       mod_val;
  logic [5:0]       force_v;
  logic [2:0]       db_hi;
  logic [2:0]       db_lo;

  // high when the channel is on at this count
  function automatic logic duty_on(input logic [11:0] c,
                                   input logic [15:0] d,
                                   input logic [11:0] r);
    if (d[15]) begin
      duty_on = 1'b0;
    end else if (d[12:0] > {1'b0, r}) begin
      duty_on = 1'b1;
    end else begin
      duty_on = {1'b0, c} < d[12:0];
    end
  endfunction : duty_on

  assign en    = ctl_main_q[MAIN_EN_BIT];
  assign align = ctl_main_q[MAIN_ALIGN_BIT];
  assign indep = ctl_aux_q[AUX_INDEP_BIT];
  assign pol   = ctl_aux_q[AUX_POL_MSB:AUX_POL_LSB];

  assign duty_hit = (reg_addr_in >= ADDR_DUTY_BASE) &&
                    (reg_addr_in <= ADDR_DUTY_LAST);
  assign duty_off = reg_addr_in - ADDR_DUTY_BASE;
  assign duty_idx = duty_off[3:1];

  // ---- register writes ----
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_main_q <= MAIN_RST;
    end else if (reg_wr_in && (reg_addr_in == ADDR_CTL_MAIN)) begin
      // a write in the transfer cycle wins, so a fresh ready survives
      ctl_main_q <= reg_wdata_in & MAIN_WMASK;
    end else if (reload_evt && ctl_main_q[MAIN_READY_BIT]) begin
      ctl_main_q[MAIN_READY_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_aux_q  <= AUX_RST;
      dead_q     <= DEAD_RST;
      mask_q     <= MASK_RST;
      reload_h_q <= RELOAD_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_CTL_AUX:  ctl_aux_q  <= reg_wdata_in;
        ADDR_DEADBAND: dead_q     <= reg_wdata_in;
        ADDR_OUT_MASK: mask_q     <= reg_wdata_in[5:0];
        ADDR_RLD_HI:   reload_h_q[11:8] <= reg_wdata_in[3:0];
        ADDR_RLD_LO:   reload_h_q[7:0]  <= reg_wdata_in;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_h_q[i] <= DUTY_RST;
      end
    end else if (reg_wr_in && duty_hit) begin
      if (duty_off[0]) begin
        duty_h_q[duty_idx][7:0] <= reg_wdata_in;
      end else begin
        duty_h_q[duty_idx][15:8] <= reg_wdata_in & DUTY_HI_MASK;
      end
    end
  end

  // ---- register reads: holding values, except the live count ----
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_in)
      ADDR_CTL_MAIN: rd_mux = ctl_main_q;
      ADDR_CTL_AUX:  rd_mux = ctl_aux_q;
      ADDR_DEADBAND: rd_mux = dead_q;
      ADDR_OUT_MASK: rd_mux = {2'h0, mask_q};
      ADDR_CNT_HI:   rd_mux = {4'h0, cnt_q[11:8]};
      ADDR_CNT_LO:   rd_mux = cnt_q[7:0];
      ADDR_RLD_HI:   rd_mux = {4'h0, reload_h_q[11:8]};
      ADDR_RLD_LO:   rd_mux = reload_h_q[7:0];
      default: begin
        if (duty_hit) begin
          rd_mux = duty_off[0] ? duty_h_q[duty_idx][7:0]
                               : duty_h_q[duty_idx][15:8];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ---- clock divide and master counter ----
  mpwm_prescaler u_presc (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (en),
    .div_sel_in (div_w_q),
    .tick_out   (tick)
  );

  // a zero reload would never end a period, so it acts as one
  assign r_eff = (reload_w_q == 12'h000) ? 12'h001 : reload_w_q;

  assign period_end = tick &&
    (((dir_q == MPWM_UP) && !align && (cnt_q >= r_eff - 12'h001)) ||
     ((dir_q == MPWM_DOWN) && (cnt_q <= 12'h001)));

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 12'h000;
      dir_q <= MPWM_UP;
    end else if (!en) begin
      cnt_q <= 12'h000;
      dir_q <= MPWM_UP;
    end else if (tick) begin
      case (dir_q)
        MPWM_UP: begin
          if (!align) begin
            cnt_q <= period_end ? 12'h000 : cnt_q + 12'h001;
          end else begin
            cnt_q <= cnt_q + 12'h001;
            if ((cnt_q + 12'h001) >= r_eff) begin
              dir_q <= MPWM_DOWN;
            end
          end
        end
        MPWM_DOWN: begin
          cnt_q <= (cnt_q <= 12'h001) ? 12'h000 : cnt_q - 12'h001;
          if (cnt_q <= 12'h001) begin
            dir_q <= MPWM_UP;
          end
        end
        default: dir_q <= MPWM_UP;
      endcase
    end
  end

  // ---- period counting and reload event ----
  assign per_match  = per_cnt_q >= mpwm_pow2_last(intv_w_q);
  assign start_evt  = en && !en_prev_q;
  assign reload_evt = start_evt || (period_end && per_match);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      per_cnt_q <= 3'h0;
      intv_w_q  <= 2'h0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en;
      if (!en) begin
        per_cnt_q <= 3'h0;
        intv_w_q  <= ctl_aux_q[AUX_INTV_MSB:AUX_INTV_LSB];
      end else if (period_end) begin
        per_cnt_q <= per_match ? 3'h0 : per_cnt_q + 3'h1;
        intv_w_q  <= ctl_aux_q[AUX_INTV_MSB:AUX_INTV_LSB];
      end
    end
  end

  // ---- holding to working transfer ----
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_w_q <= RELOAD_RST;
      div_w_q    <= 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_w_q[i] <= DUTY_RST;
      end
    end else if (reload_evt && ctl_main_q[MAIN_READY_BIT]) begin
      reload_w_q <= reload_h_q;
      div_w_q    <= ctl_aux_q[AUX_DIV_MSB:AUX_DIV_LSB];
      for (int i = 0; i < NUM_CH; i++) begin
        duty_w_q[i] <= duty_h_q[i];
      end
    end
  end

  // ---- off-state release follows the reload event ----
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      release_q <= 1'b0;
    end else if (!ctl_main_q[MAIN_OFF_BIT]) begin
      release_q <= 1'b0;
    end else if (reload_evt) begin
      release_q <= 1'b1;
    end
  end

  // ---- waveform, pairing, polarity ----
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      raw[i] = duty_on(cnt_q, duty_w_q[i], reload_w_q);
    end
  end

  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    mpwm_deadband u_dead (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .raw_in     (raw[2*p]),
      .dead_in    (dead_q),
      .high_out   (db_hi[p]),
      .low_out    (db_lo[p])
    );
    assign mod_val[2*p]   = (indep ? raw[2*p]   : db_hi[p]) ^ pol[p];
    assign mod_val[2*p+1] = (indep ? raw[2*p+1] : db_lo[p]) ^ pol[p];
  end

  // forcing bypasses polarity so the off-state is the same in every mode
  // a cleared off bit forces at once; only the release waits for reload
  assign force_v = {NUM_CH{!en || !ctl_main_q[MAIN_OFF_BIT] ||
                           !release_q}} |
                   (ctl_main_q[MAIN_SEL_BIT] ? mask_q : 6'h00);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_q  <= OFF_STATE;
      trig_q <= 1'b0;
    end else begin
      pwm_q  <= (force_v & OFF_STATE) | (~force_v & mod_val);
      trig_q <= ctl_main_q[MAIN_TRIG_BIT] && period_end;
    end
  end

  assign pwm_out        = pwm_q;
  assign pwm_oe_out     = {NUM_CH{en}};
  assign adc_trig_out   = trig_q;
  assign reload_evt_out = reload_evt;

  // ---- checks ----
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_off_cleared;
    $fell(ctl_main_q[MAIN_OFF_BIT]);
  endsequence
  property p_off_now;
    s_off_cleared |-> ##1 (pwm_out == OFF_STATE);
  endproperty
  a_off_now: assert property (p_off_now)
    else $error("outputs not off one cycle after off bit cleared");

  property p_release_at_reload;
    $rose(release_q) |-> $past(reload_evt) && $past(ctl_main_q[MAIN_OFF_BIT]);
  endproperty
  a_release_at_reload: assert property (p_release_at_reload)
    else $error("outputs released without a reload event");

  property p_sel_disable;
    ctl_main_q[MAIN_SEL_BIT] |=>
      (((pwm_out ^ OFF_STATE) & $past(mask_q)) == 6'h00);
  endproperty
  a_sel_disable: assert property (p_sel_disable)
    else $error("masked output not at off-state");

  property p_trig_gate;
    adc_trig_out |-> $past(ctl_main_q[MAIN_TRIG_BIT]) && $past(period_end);
  endproperty
  a_trig_gate: assert property (p_trig_gate)
    else $error("trigger pulse while trigger disabled");

  sequence s_ready_reload;
    reload_evt && ctl_main_q[MAIN_READY_BIT];
  endsequence
  property p_transfer;
    s_ready_reload |=> (reload_w_q == $past(reload_h_q)) &&
                       (duty_w_q[0] == $past(duty_h_q[0]));
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("holding values not moved at ready reload");

  property p_hold_unused;
    !(reload_evt && ctl_main_q[MAIN_READY_BIT]) |=>
      $stable(reload_w_q) && $stable(div_w_q);
  endproperty
  a_hold_unused: assert property (p_hold_unused)
    else $error("working values changed without ready reload");

  property p_disabled;
    !en |=> (cnt_q == 12'h000) && (pwm_out == OFF_STATE);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("counter or outputs active while disabled");

  property p_oe_follows;
    $rose(en) |-> (pwm_oe_out == 6'h3F) ##1 (pwm_oe_out == 6'h3F || !en);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("pins not driven while enabled");

  property p_every_period;
    period_end && (intv_w_q == 2'h0) |-> reload_evt;
  endproperty
  a_every_period: assert property (p_every_period)
    else $error("interval zero must reload every period");

  property p_interval_hold;
    $changed(intv_w_q) |-> $past(period_end) || !$past(en);
  endproperty
  a_interval_hold: assert property (p_interval_hold)
    else $error("interval changed away from a period end");

  property p_center_double;
    en && align && (dir_q == MPWM_UP) && (cnt_q == 12'h000) && tick &&
      (r_eff == 12'h004) && (div_w_q == 2'h0) ##1 (en && align) [*7]
      |-> period_end;
  endproperty
  a_center_double: assert property (p_center_double)
    else $error("center period must span twice the reload");

endmodule : mpwm_ctrl

// File: core/mpwm_deadband.sv
// deadband: complementary pair from one raw wave with a dead gap per edge
`timescale 1ns/1ps
module mpwm_deadband
  import mpwm_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // wave and dead time
  input  wire logic       raw_in,
  input  wire logic [7:0] dead_in,
  // pair outputs
  output logic            high_out,
  output logic            low_out
);

  logic       raw_q;
  logic [7:0] dead_cnt_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      raw_q      <= 1'b0;
      dead_cnt_q <= 8'h00;
      high_out   <= 1'b0;
      low_out    <= 1'b0;
    end else if (raw_in != raw_q) begin
      // a zero setting still gives one dead cycle
      raw_q      <= raw_in;
      dead_cnt_q <= (dead_in == 8'h00) ? 8'h00 : dead_in - 8'h01;
      high_out   <= 1'b0;
      low_out    <= 1'b0;
    end else if (dead_cnt_q != 8'h00) begin
      dead_cnt_q <= dead_cnt_q - 8'h01;
      high_out   <= 1'b0;
      low_out    <= 1'b0;
    end else begin
      high_out   <= raw_q;
      low_out    <= !raw_q;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_dead_gap;
    (raw_in != raw_q) && (dead_in == 8'h03) ##1 (raw_in == raw_q) [*2]
      |-> !high_out && !low_out ##1 !high_out && !low_out;
  endproperty
  a_dead_gap: assert property (p_dead_gap)
    else $error("pair must stay dead for the programmed cycles");

  property p_no_overlap;
    !(high_out && low_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both outputs of a pair asserted together");

endmodule : mpwm_deadband

// File: core/mpwm_pkg.sv
// package: register map, field positions, reset values and shared helpers
package mpwm_pkg;

  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 8;
  localparam int NUM_CH   = 6;
  localparam int NUM_PAIR = 3;
  localparam int CNT_W    = 12;

  // register offsets
  localparam logic [11:0] ADDR_CTL_MAIN  = 12'hF20;
  localparam logic [11:0] ADDR_CTL_AUX   = 12'hF21;
  localparam logic [11:0] ADDR_DEADBAND  = 12'hF22;
  localparam logic [11:0] ADDR_OUT_MASK  = 12'hF28;
  localparam logic [11:0] ADDR_CNT_HI    = 12'hF2C;
  localparam logic [11:0] ADDR_CNT_LO    = 12'hF2D;
  localparam logic [11:0] ADDR_RLD_HI    = 12'hF2E;
  localparam logic [11:0] ADDR_RLD_LO    = 12'hF2F;
  localparam logic [11:0] ADDR_DUTY_BASE = 12'hF30;
  localparam logic [11:0] ADDR_DUTY_LAST = 12'hF3B;

  // main control fields
  localparam int MAIN_OFF_BIT   = 7;
  localparam int MAIN_SEL_BIT   = 6;
  localparam int MAIN_ALIGN_BIT = 5;
  localparam int MAIN_TRIG_BIT  = 3;
  localparam int MAIN_READY_BIT = 1;
  localparam int MAIN_EN_BIT    = 0;

  // auxiliary control fields
  localparam int AUX_INTV_MSB  = 7;
  localparam int AUX_INTV_LSB  = 6;
  localparam int AUX_INDEP_BIT = 5;
  localparam int AUX_POL_MSB   = 4;
  localparam int AUX_POL_LSB   = 2;
  localparam int AUX_DIV_MSB   = 1;
  localparam int AUX_DIV_LSB   = 0;

  // write masks and reset values
  localparam logic [7:0]  MAIN_WMASK   = 8'hEB;
  localparam logic [7:0]  DUTY_HI_MASK = 8'h9F;
  localparam logic [7:0]  MAIN_RST     = 8'h00;
  localparam logic [7:0]  AUX_RST      = 8'h00;
  localparam logic [7:0]  DEAD_RST     = 8'h01;
  localparam logic [5:0]  MASK_RST     = 6'h00;
  localparam logic [11:0] RELOAD_RST   = 12'hFFF;
  localparam logic [15:0] DUTY_RST     = 16'h0000;

  typedef enum logic {MPWM_UP, MPWM_DOWN} mpwm_dir_t;

  // last count of a power-of-two interval selected by a 2-bit code
  function automatic logic [2:0] mpwm_pow2_last(input logic [1:0] sel);
    mpwm_pow2_last = 3'((4'h1 << sel) - 4'h1);
  endfunction : mpwm_pow2_last

endpackage : mpwm_pkg

// File: core/mpwm_prescaler.sv
// prescaler: one-cycle tick every 1, 2, 4 or 8 system clocks
`timescale 1ns/1ps
module mpwm_prescaler
  import mpwm_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // control
  input  wire logic       run_in,
  input  wire logic [1:0] div_sel_in,
  // tick
  output logic            tick_out
);

  logic [2:0] div_cnt_q;
  logic [2:0] div_last;

  assign div_last = mpwm_pow2_last(div_sel_in);
  // >= so a smaller divide taken mid-count ends the count at once
  assign tick_out = run_in && (div_cnt_q >= div_last);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_q <= 3'h0;
    end else if (!run_in || tick_out) begin
      div_cnt_q <= 3'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_div_one;
    run_in && (div_sel_in == 2'h0) |-> tick_out;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("divide by one must tick every cycle");

  sequence s_div8_wait;
    tick_out ##1 (run_in && (div_sel_in == 2'h3) && !tick_out) [*7];
  endsequence
  property p_div_eight;
    s_div8_wait ##1 (run_in && (div_sel_in == 2'h3)) |-> tick_out;
  endproperty
  a_div_eight: assert property (p_div_eight)
    else $error("divide by eight must tick on the eighth cycle");

endmodule : mpwm_prescaler

// File: verif/mpwm_gate_model.sv
// gate driver inputs on the six output pins, pulled down when undriven
`timescale 1ns/1ps
module mpwm_gate_model (
  // pins from the block
  input  wire logic [5:0] pin_drive_in,
  input  wire logic [5:0] pin_oe_in,
  // level seen by the power stage
  output logic      [5:0] pin_level_out
);
  // pull-down keeps a released gate off rather than floating
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_level_out[i] = pin_oe_in[i] ? pin_drive_in[i] : 1'b0;
    end
  end
endmodule : mpwm_gate_model

// File: verif/testbench.sv
// testbench: registers, reload timing, prescale and pin forcing
`timescale 1ns/1ps
module testbench;
  import mpwm_pkg::*;
  logic              sys_clk_in   = 1'b0;
  logic              reset_n_in   = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in  = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0;
  logic              reg_wr_in    = 1'b0;
  logic              reg_rd_in    = 1'b0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic [NUM_CH-1:0] pwm_out;
  logic [NUM_CH-1:0] pwm_oe_out;
  logic [NUM_CH-1:0] pin_level;
  logic              adc_trig_out;
  logic              reload_evt_out;
  int                n_errors     = 0;
  int                num_checks   = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  mpwm_ctrl #(.OFF_STATE(6'h00)) u_dut (
    .sys_clk_in     (sys_clk_in),
    .reset_n_in     (reset_n_in),
    .reg_addr_in    (reg_addr_in),
    .reg_wdata_in   (reg_wdata_in),
    .reg_wr_in      (reg_wr_in),
    .reg_rd_in      (reg_rd_in),
    .reg_rdata_out  (reg_rdata_out),
    .pwm_out        (pwm_out),
    .pwm_oe_out     (pwm_oe_out),
    .adc_trig_out   (adc_trig_out),
    .reload_evt_out (reload_evt_out)
  );

  mpwm_gate_model u_gate (
    .pin_drive_in  (pwm_out),
    .pin_oe_in     (pwm_oe_out),
    .pin_level_out (pin_level)
  );

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk_val(reg_rdata_out, exp);
  endtask : rd_chk

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cycles

  // bounded wait for the combinational reload pulse, sampled mid-cycle
  task automatic next_evt;
    for (int t = 0; t < 2000; t++) begin
      @(negedge sys_clk_in);
      if (reload_evt_out === 1'b1) return;
    end
    n_errors++;
    $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
  endtask : next_evt

  // skip events so buffered settings have landed, then time one interval
  task automatic gap(input int exp);
    time t0;
    next_evt();
    next_evt();
    next_evt();
    t0 = $time;
    next_evt();
    chk_cnt(int'(($time - t0) / 10), exp);
  endtask : gap

  task automatic t_regs;
    rd_chk(ADDR_CTL_MAIN, MAIN_RST);
    rd_chk(ADDR_CTL_AUX, AUX_RST);
    rd_chk(ADDR_DEADBAND, DEAD_RST);
    wr(ADDR_DEADBAND, 8'h03);
    rd_chk(ADDR_DEADBAND, 8'h03);
    rd_chk(ADDR_RLD_HI, 8'h0F);
    rd_chk(ADDR_RLD_LO, 8'hFF);
    rd_chk(12'hF40, 8'h00);
    wr(ADDR_CTL_MAIN, 8'h14);
    rd_chk(ADDR_CTL_MAIN, 8'h00);
    wr(ADDR_CTL_AUX, 8'hC3);
    rd_chk(ADDR_CTL_AUX, 8'hC3);
    wr(ADDR_CTL_AUX, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_start;
    wr(ADDR_RLD_HI, 8'h00);
    wr(ADDR_RLD_LO, 8'h04);
    for (int i = 0; i < 12; i += 2) begin
      wr(ADDR_DUTY_BASE + 12'(i), 8'h00);
      wr(ADDR_DUTY_BASE + 12'(i + 1), 8'h10);
    end
    wr(ADDR_CTL_MAIN, 8'h83);
    #1;
    chk_val({2'b00, pwm_oe_out}, 8'h3F);
    chk_val({7'h00, reload_evt_out}, 8'h01);
    // three dead cycles after the first raw edge keep both sides low
    cycles(5);
    chk_val({2'b00, pin_level}, 8'h00);
    cycles(7);
    chk_val({2'b00, pin_level}, 8'h15);
    $display("test start done");
  endtask : t_start

  task automatic t_off;
    wr(ADDR_CTL_MAIN, 8'h01);
    cycles(1);
    chk_val({2'b00, pwm_out}, 8'h00);
    wr(ADDR_CTL_MAIN, 8'h81);
    next_evt();
    chk_val({2'b00, pwm_out}, 8'h00);
    cycles(3);
    chk_val({2'b00, pwm_out}, 8'h15);
    $display("test off done");
  endtask : t_off

  task automatic t_interval;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL_AUX, {2'(k), 6'h00});
      gap(4 << k);
    end
    wr(ADDR_CTL_AUX, 8'h00);
    $display("test interval done");
  endtask : t_interval

  task automatic t_div;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CTL_AUX, {6'h00, 2'(d)});
      wr(ADDR_CTL_MAIN, 8'h83);
      gap(4 << d);
    end
    wr(ADDR_CTL_AUX, 8'h00);
    gap(32);
    wr(ADDR_CTL_MAIN, 8'h83);
    gap(4);
    wr(ADDR_CTL_MAIN, 8'hA1);
    gap(8);
    wr(ADDR_CTL_MAIN, 8'h81);
    $display("test divide done");
  endtask : t_div

  task automatic t_trig;
    int n;
    for (int on = 0; on < 2; on++) begin
      wr(ADDR_CTL_MAIN, on ? 8'h89 : 8'h81);
      cycles(8);
      n = 0;
      repeat (40) begin
        @(negedge sys_clk_in);
        if (adc_trig_out === 1'b1) n++;
      end
      chk_cnt(n, on ? 10 : 0);
    end
    $display("test trigger done");
  endtask : t_trig

  task automatic t_mode;
    wr(ADDR_CTL_MAIN, 8'h80);
    cycles(2);
    chk_val({2'b00, pwm_oe_out}, 8'h00);
    chk_val({2'b00, pwm_out}, 8'h00);
    // mode bit only changes while the modulator is stopped
    wr(ADDR_CTL_AUX, 8'h20);
    wr(ADDR_CTL_MAIN, 8'h83);
    cycles(12);
    chk_val({2'b00, pwm_out}, 8'h3F);
    wr(ADDR_CTL_AUX, 8'h28);
    cycles(12);
    chk_val({2'b00, pwm_out}, 8'h33);
    wr(ADDR_OUT_MASK, 8'h11);
    wr(ADDR_CTL_MAIN, 8'hC1);
    cycles(3);
    chk_val({2'b00, pwm_out}, 8'h22);
    $display("test mode done");
  endtask : t_mode

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // a hang anywhere ends the run through the normal closing path
  initial begin
    #500us;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_start();
    t_off();
    t_interval();
    t_div();
    t_trig();
    t_mode();
    report_and_stop();
  end
endmodule : testbench
